/* shared/sensor_irq_pkg.sv */
// Summary of operation
// - the alert pin is driven only while the pin output-enable bit is set, else it stays idle.
// - with the pin output-enable bit set, the alert pin is asserted whenever the source mask ANDed with the pending flags is nonzero.
// - writing a one to a flag bit clears exactly that flag.
// - when each flag is set follows from the source mask alone; the two mode registers are only stored and read back.
// - with mask bit 2 set, proximity one sets its flag after every sample, else never.
// - with mask bit 3 set, proximity two sets its flag after every sample, else never.
// - with mask bit 4 set, proximity three sets its flag after every sample, else never.
// - mask field 1:0 at 00 gives no ambient flag, at 01 every visible or uv sample sets it.
package sensor_irq_pkg;

  // ----------------------------------------
  // register offsets
  // ----------------------------------------
  localparam logic [7:0] alert_pin_config_off     = 8'h03;
  localparam logic [7:0] source_enable_mask_off   = 8'h04;
  localparam logic [7:0] interrupt_mode_one_off   = 8'h05;
  localparam logic [7:0] interrupt_mode_two_off   = 8'h06;
  localparam logic [7:0] pending_source_flags_off = 8'h21;

  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int pin_oe_bit      = 0;
  localparam int ambient_lo_bit  = 0;
  localparam int ambient_hi_bit  = 1;
  localparam int prox_one_bit    = 2;
  localparam int prox_two_bit    = 3;
  localparam int prox_three_bit  = 4;
  localparam int flag_width      = 5;
  localparam logic [1:0] ambient_every_sample = 2'h1;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] alert_pin_config_rst     = 8'h00;
  localparam logic [4:0] source_enable_mask_rst   = 5'h00;
  localparam logic [7:0] interrupt_mode_rst       = 8'h00;
  localparam logic [4:0] pending_source_flags_rst = 5'h00;

  // ----------------------------------------
  // serial link
  // ----------------------------------------
  localparam logic [6:0] link_address_dflt = 7'h5a;  // arbitrary
  localparam logic [3:0] bits_per_byte     = 4'h8;

  typedef enum logic [3:0] {
    st_idle  = 4'h0,
    st_addr  = 4'h1,
    st_aack  = 4'h3,
    st_reg   = 4'h2,
    st_rack  = 4'h6,
    st_wdata = 4'h7,
    st_wack  = 4'h5,
    st_rdata = 4'h4,
    st_mack  = 4'hc
  } link_state_type;

endpackage

/* src/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int width = 2
) (
  input  wire logic             clk_sys,
  input  wire logic             rstn,
  input  wire logic [width-1:0] pin_in,
  output logic      [width-1:0] pin_out
);

  // ----------------------------------------
  // two flip-flops per bit
  // ----------------------------------------
  genvar i;
  generate
    for (i = 0; i < width; i++) begin : g_bit
      logic stage_a_r;
      logic stage_b_r;
      always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
          stage_a_r <= 1'b1;
          stage_b_r <= 1'b1;
        end else begin
          stage_a_r <= pin_in[i];
          stage_b_r <= stage_a_r;
        end
      end
      assign pin_out[i] = stage_b_r;
    end
  endgenerate

endmodule // pin_sync

/* src/sensor_interrupt_logic.sv */
`timescale 1ns/1ps
module sensor_interrupt_logic #(
  parameter logic [6:0] link_address = sensor_irq_pkg::link_address_dflt
) (
  input  wire logic clk_sys,
  input  wire logic rstn,
  input  wire logic scl,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic prox_one_sample,
  input  wire logic prox_two_sample,
  input  wire logic prox_three_sample,
  input  wire logic visible_sample,
  input  wire logic uv_sample,
  output logic      alert_n
);

  // ----------------------------------------
  // pin sampling
  // ----------------------------------------
  logic [1:0] pins_s;
  logic       scl_s;
  logic       sda_s;
  logic       scl_d_r;
  logic       sda_d_r;
  logic       scl_rise;
  logic       scl_fall;
  logic       start_cond;
  logic       stop_cond;

  pin_sync #(.width(2)) u_sync (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .pin_in  ({scl, sda_in}),
    .pin_out (pins_s)
  );

  assign scl_s      = pins_s[1];
  assign sda_s      = pins_s[0];
  assign scl_rise   = scl_s & ~scl_d_r;
  assign scl_fall   = ~scl_s & scl_d_r;
  assign start_cond = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_cond  = scl_s & scl_d_r & ~sda_d_r & sda_s;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
    end
  end

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] pin_cfg_r;
  logic [7:0] pin_cfg_nxt;
  logic [4:0] mask_r;
  logic [4:0] mask_nxt;
  logic [7:0] mode_one_r;
  logic [7:0] mode_one_nxt;
  logic [7:0] mode_two_r;
  logic [7:0] mode_two_nxt;
  logic [4:0] flags_r;
  logic [4:0] flags_nxt;
  logic [4:0] flag_set;
  logic [4:0] flag_clr;
  logic       alert_r;
  logic       alert_nxt;
  logic       wr_en;
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  logic [7:0] rd_data;

  // ----------------------------------------
  // serial link state
  // ----------------------------------------
  sensor_irq_pkg::link_state_type state_r;
  sensor_irq_pkg::link_state_type state_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic       rw_r;
  logic       rw_nxt;
  logic       drv_r;
  logic       drv_nxt;
  logic       nack_r;
  logic       nack_nxt;

  always_comb begin
    rd_data = 8'h00;
    case (ptr_r)
      sensor_irq_pkg::alert_pin_config_off:     rd_data = pin_cfg_r;
      sensor_irq_pkg::source_enable_mask_off:   rd_data = {3'h0, mask_r};
      sensor_irq_pkg::interrupt_mode_one_off:   rd_data = mode_one_r;
      sensor_irq_pkg::interrupt_mode_two_off:   rd_data = mode_two_r;
      sensor_irq_pkg::pending_source_flags_off: rd_data = {3'h0, flags_r};
      default:                                  rd_data = 8'h00;
    endcase
  end

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt   = ptr_r;
    rw_nxt    = rw_r;
    drv_nxt   = drv_r;
    nack_nxt  = nack_r;
    wr_en     = 1'b0;
    wr_addr   = ptr_r;
    wr_data   = shift_r;
    if (start_cond) begin
      state_nxt = sensor_irq_pkg::st_addr;
      cnt_nxt   = 4'h0;
      drv_nxt   = 1'b0;
    end else if (stop_cond) begin
      state_nxt = sensor_irq_pkg::st_idle;
      drv_nxt   = 1'b0;
    end else if (scl_rise) begin
      case (state_r)
        sensor_irq_pkg::st_addr, sensor_irq_pkg::st_reg, sensor_irq_pkg::st_wdata: begin
          shift_nxt = {shift_r[6:0], sda_s};
          cnt_nxt   = cnt_r + 4'h1;
        end
        sensor_irq_pkg::st_rdata: cnt_nxt = cnt_r + 4'h1;
        sensor_irq_pkg::st_mack:  nack_nxt = sda_s;
        default:                  cnt_nxt = cnt_r;
      endcase
    end else if (scl_fall) begin
      case (state_r)
        sensor_irq_pkg::st_addr: begin
          if (cnt_r == sensor_irq_pkg::bits_per_byte) begin
            if (shift_r[7:1] == link_address) begin
              state_nxt = sensor_irq_pkg::st_aack;
              rw_nxt    = shift_r[0];
              drv_nxt   = 1'b1;
            end else begin
              state_nxt = sensor_irq_pkg::st_idle;
            end
          end
        end
        sensor_irq_pkg::st_aack: begin
          cnt_nxt = 4'h0;
          if (rw_r) begin
            state_nxt = sensor_irq_pkg::st_rdata;
            shift_nxt = rd_data;
            drv_nxt   = ~rd_data[7];
            ptr_nxt   = ptr_r + 8'h01;
          end else begin
            state_nxt = sensor_irq_pkg::st_reg;
            drv_nxt   = 1'b0;
          end
        end
        sensor_irq_pkg::st_reg: begin
          if (cnt_r == sensor_irq_pkg::bits_per_byte) begin
            state_nxt = sensor_irq_pkg::st_rack;
            ptr_nxt   = shift_r;
            drv_nxt   = 1'b1;
          end
        end
        sensor_irq_pkg::st_wdata: begin
          if (cnt_r == sensor_irq_pkg::bits_per_byte) begin
            state_nxt = sensor_irq_pkg::st_wack;
            wr_en     = 1'b1;
            ptr_nxt   = ptr_r + 8'h01;
            drv_nxt   = 1'b1;
          end
        end
        sensor_irq_pkg::st_rack, sensor_irq_pkg::st_wack: begin
          state_nxt = sensor_irq_pkg::st_wdata;
          cnt_nxt   = 4'h0;
          drv_nxt   = 1'b0;
        end
        sensor_irq_pkg::st_rdata: begin
          if (cnt_r == sensor_irq_pkg::bits_per_byte) begin
            state_nxt = sensor_irq_pkg::st_mack;
            drv_nxt   = 1'b0;
          end else begin
            shift_nxt = {shift_r[6:0], 1'b0};
            drv_nxt   = ~shift_r[6];
          end
        end
        sensor_irq_pkg::st_mack: begin
          cnt_nxt = 4'h0;
          if (nack_r) begin
            state_nxt = sensor_irq_pkg::st_idle;
          end else begin
            state_nxt = sensor_irq_pkg::st_rdata;
            shift_nxt = rd_data;
            drv_nxt   = ~rd_data[7];
            ptr_nxt   = ptr_r + 8'h01;
          end
        end
        default: state_nxt = state_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r <= sensor_irq_pkg::st_idle;
      cnt_r   <= 4'h0;
      shift_r <= 8'h00;
      ptr_r   <= 8'h00;
      rw_r    <= 1'b0;
      drv_r   <= 1'b0;
      nack_r  <= 1'b1;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r   <= ptr_nxt;
      rw_r    <= rw_nxt;
      drv_r   <= drv_nxt;
      nack_r  <= nack_nxt;
    end
  end

  assign sda_out = 1'b0;
  assign sda_oe  = drv_r;

  // ----------------------------------------
  // flag setting and clearing
  // ----------------------------------------
  always_comb begin
    flag_set = 5'h00;
    flag_set[sensor_irq_pkg::prox_one_bit]   = prox_one_sample
      & mask_r[sensor_irq_pkg::prox_one_bit];
    flag_set[sensor_irq_pkg::prox_two_bit]   = prox_two_sample
      & mask_r[sensor_irq_pkg::prox_two_bit];
    flag_set[sensor_irq_pkg::prox_three_bit] = prox_three_sample
      & mask_r[sensor_irq_pkg::prox_three_bit];
    flag_set[sensor_irq_pkg::ambient_lo_bit] = (visible_sample | uv_sample)
      & (mask_r[sensor_irq_pkg::ambient_hi_bit:sensor_irq_pkg::ambient_lo_bit]
         == sensor_irq_pkg::ambient_every_sample);
  end

  always_comb begin
    pin_cfg_nxt  = pin_cfg_r;
    mask_nxt     = mask_r;
    mode_one_nxt = mode_one_r;
    mode_two_nxt = mode_two_r;
    flag_clr     = 5'h00;
    if (wr_en) begin
      case (wr_addr)
        sensor_irq_pkg::alert_pin_config_off:     pin_cfg_nxt  = wr_data;
        sensor_irq_pkg::source_enable_mask_off:   mask_nxt     = wr_data[4:0];
        sensor_irq_pkg::interrupt_mode_one_off:   mode_one_nxt = wr_data;
        sensor_irq_pkg::interrupt_mode_two_off:   mode_two_nxt = wr_data;
        sensor_irq_pkg::pending_source_flags_off: flag_clr     = wr_data[4:0];
        default:                                  flag_clr     = 5'h00;
      endcase
    end
    flags_nxt = (flags_r & ~flag_clr) | flag_set;
    alert_nxt = pin_cfg_r[sensor_irq_pkg::pin_oe_bit]
              & (|(mask_r & flags_r));
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pin_cfg_r  <= sensor_irq_pkg::alert_pin_config_rst;
      mask_r     <= sensor_irq_pkg::source_enable_mask_rst;
      mode_one_r <= sensor_irq_pkg::interrupt_mode_rst;
      mode_two_r <= sensor_irq_pkg::interrupt_mode_rst;
      flags_r    <= sensor_irq_pkg::pending_source_flags_rst;
      alert_r    <= 1'b0;
    end else begin
      pin_cfg_r  <= pin_cfg_nxt;
      mask_r     <= mask_nxt;
      mode_one_r <= mode_one_nxt;
      mode_two_r <= mode_two_nxt;
      flags_r    <= flags_nxt;
      alert_r    <= alert_nxt;
    end
  end

  assign alert_n = ~alert_r;

endmodule // sensor_interrupt_logic

/* testbench/sensor_irq_assertions.sv */
`timescale 1ns/1ps
// ----------------------------------------
// port checks
// ----------------------------------------
module sensor_irq_assertions (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic scl,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic prox_one_sample,
  input wire logic prox_two_sample,
  input wire logic prox_three_sample,
  input wire logic visible_sample,
  input wire logic uv_sample,
  input wire logic alert_n
);
  logic       any_smp;
  logic       scl_r, scl_nxt;
  logic [3:0] quiet_r, quiet_nxt;
  assign any_smp = prox_one_sample | prox_two_sample | prox_three_sample | visible_sample
                 | uv_sample;
  always_comb begin
    scl_nxt   = scl;
    quiet_nxt = (scl != scl_r) ? 4'h0 : (quiet_r == 4'hf) ? quiet_r : quiet_r + 4'h1;
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      scl_r   <= 1'b1;
      quiet_r <= 4'h0;
    end else begin
      scl_r   <= scl_nxt;
      quiet_r <= quiet_nxt;
    end
  end
  sequence quiet_fall;
    quiet_r >= 4'hc && $fell(alert_n);
  endsequence
  chk_alert_cause: assert property (
    @(posedge clk_sys) disable iff (!rstn) quiet_fall |-> $past(any_smp, 2))
    else $error("alert fell without a sample");
  chk_alert_latency: assert property (
    @(posedge clk_sys) disable iff (!rstn) alert_n && any_smp && quiet_r >= 4'hc |=> alert_n)
    else $error("alert came too early");
  chk_alert_hold: assert property (
    @(posedge clk_sys) disable iff (!rstn) !alert_n && quiet_r >= 4'hc |=> !alert_n)
    else $error("alert cleared without a write");
  chk_oe_rise: assert property (
    @(posedge clk_sys) disable iff (!rstn) $rose(sda_oe) |-> !scl)
    else $error("data pulled while clock high");
  chk_oe_fall: assert property (
    @(posedge clk_sys) disable iff (!rstn) $fell(sda_oe) |-> !scl)
    else $error("data released while clock high");
  chk_bus_released: assert property (
    @(posedge clk_sys) disable iff (!rstn) quiet_r == 4'hf |-> !sda_oe)
    else $error("data held on idle bus");
  chk_reset_idle: assert property (
    @(posedge clk_sys) !rstn |-> alert_n && !sda_oe)
    else $error("outputs active in reset");
  chk_drive_low: assert property (
    @(posedge clk_sys) disable iff (!rstn) sda_oe |-> !sda_out)
    else $error("data driven high");
endmodule // sensor_irq_assertions

/* testbench/host_model.sv */
`timescale 1ns/1ps
// ----------------------------------------
// link master, open drain
// ----------------------------------------
module host_model #(
  parameter logic [6:0] addr = sensor_irq_pkg::link_address_dflt
) (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  initial begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end
  task automatic bitx(input logic b, output logic r);
    #12 sda_low = ~b;
    #12 scl = 1'b1;
    #12 r = sda;
    #12 scl = 1'b0;
  endtask
  task automatic start();
    #12 sda_low = 1'b0;
    #12 scl = 1'b1;
    #12 sda_low = 1'b1;
    #12 scl = 1'b0;
  endtask
  task automatic stop();
    #12 sda_low = 1'b1;
    #12 scl = 1'b1;
    #12 sda_low = 1'b0;
    #12;
  endtask
  task automatic byte_x(input logic [7:0] d, output logic [7:0] r, output logic ack);
    logic n;
    for (int i = 7; i >= 0; i--) bitx(d[i], r[i]);
    bitx(1'b1, n);
    ack = ~n;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a1, a2, a3;
    start();
    byte_x({addr, 1'b0}, q, a1);
    byte_x(p, q, a2);
    byte_x(d, q, a3);
    stop();
    ok = a1 & a2 & a3;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
    logic [7:0] q;
    logic a1, a2, a3, n;
    start();
    byte_x({addr, 1'b0}, q, a1);
    byte_x(p, q, a2);
    start();
    byte_x({addr, 1'b1}, q, a3);
    byte_x(8'hff, d, n);
    stop();
    ok = a1 & a2 & a3;
  endtask
endmodule // host_model

/* testbench/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
  logic       clk_sys = 1'b1;
  logic       rstn    = 1'b1;
  logic [4:0] smp     = 5'h00;
  logic       scl, host_low, sda_out, sda_oe, alert_n, ok;
  logic [7:0] v;
  wire        sda = ~(host_low | (sda_oe & ~sda_out));
  int         fails   = 0;
  int         n_tests = 0;
  int         cyc     = 0;
  always #2 clk_sys = ~clk_sys;
  host_model u_host (.scl(scl), .sda_low(host_low), .sda(sda));
  sensor_interrupt_logic u_sensor_interrupt_logic (
    .clk_sys(clk_sys), .rstn(rstn), .scl(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .prox_one_sample(smp[2]), .prox_two_sample(smp[3]),
    .prox_three_sample(smp[4]), .visible_sample(smp[0]), .uv_sample(smp[1]),
    .alert_n(alert_n));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    u_host.wr(p, d, ok);
    chk("write ack", 8'h01, {7'h00, ok});
  endtask
  task automatic rd(input logic [7:0] p, input logic [7:0] e);
    u_host.rd(p, v, ok);
    chk("read ack", 8'h01, {7'h00, ok});
    chk("read data", e, v);
  endtask
  task automatic pulse(input logic [4:0] s);
    repeat (16) @(negedge clk_sys);
    smp = s;
    @(negedge clk_sys);
    smp = 5'h00;
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      results();
    end
  end
  initial begin
    @(negedge clk_sys);
    rstn = 1'b0;
    repeat (20) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (40) @(negedge clk_sys);
    chk("alert idle", 8'h01, {7'h00, alert_n});
    rd(8'h03, 8'h00);
    rd(8'h04, 8'h00);
    rd(8'h21, 8'h00);
    wr(8'h05, 8'ha5);
    rd(8'h05, 8'ha5);
    wr(8'h06, 8'h3c);
    rd(8'h06, 8'h3c);
    rd(8'h40, 8'h00);
    u_host.start();
    u_host.byte_x(8'h22, v, ok);
    u_host.stop();
    chk("foreign ack", 8'h00, {7'h00, ok});
    pulse(5'h1f);
    rd(8'h21, 8'h00);
    wr(8'h04, 8'h02);
    pulse(5'h03);
    rd(8'h21, 8'h00);
    wr(8'h04, 8'h1d);
    wr(8'h03, 8'h01);
    rd(8'h03, 8'h01);
    for (int i = 0; i < 5; i++) begin
      pulse(5'h01 << i);
      chk("alert set", 8'h00, {7'h00, alert_n});
      rd(8'h21, (i < 2) ? 8'h01 : 8'h01 << i);
      wr(8'h21, v);
      chk("alert clear", 8'h01, {7'h00, alert_n});
    end
    pulse(5'h1f);
    wr(8'h21, 8'h04);
    rd(8'h21, 8'h19);
    wr(8'h21, 8'h00);
    rd(8'h21, 8'h19);
    wr(8'h03, 8'h00);
    chk("alert off", 8'h01, {7'h00, alert_n});
    wr(8'h03, 8'h01);
    chk("alert on", 8'h00, {7'h00, alert_n});
    wr(8'h04, 8'h00);
    chk("alert masked", 8'h01, {7'h00, alert_n});
    rd(8'h21, 8'h19);
    @(negedge clk_sys);
    rstn = 1'b0;
    repeat (4) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (4) @(negedge clk_sys);
    chk("alert after reset", 8'h01, {7'h00, alert_n});
    rd(8'h21, 8'h00);
    rd(8'h03, 8'h00);
    results();
  end
endmodule // tb_top
bind sensor_interrupt_logic sensor_irq_assertions u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe),
  .prox_one_sample(prox_one_sample), .prox_two_sample(prox_two_sample),
  .prox_three_sample(prox_three_sample), .visible_sample(visible_sample),
  .uv_sample(uv_sample), .alert_n(alert_n));
